// [lcd_defs.vh]
// constants shared by the character display host port and its fifo
`ifndef LCD_DEFS_VH
`define LCD_DEFS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ        50
`define EXEC_TIME_NS   40000
`define EXEC_CYCLES    ((`EXEC_TIME_NS * `CLK_MHZ) / 1000)
`define BUSY_W         12
`define BLINK_W        24

// ----------------------------------------
// command decode bit positions
// ----------------------------------------
`define CMD_TEXT_ADDR  7
`define CMD_GLYPH_ADDR 6
`define CMD_FUNCTION   5
`define CMD_SHIFT      4
`define CMD_DISPLAY    3
`define CMD_ENTRY      2
`define CMD_HOME       1
`define CMD_CLEAR      0
`define FN_WIDTH_BIT   4
`define FN_LINES_BIT   3
`define FN_FONT_BIT    2
`define SH_DISP_BIT    3
`define SH_RIGHT_BIT   2
`define DC_ON_BIT      2
`define DC_CURSOR_BIT  1
`define DC_BLINK_BIT   0
`define EM_INC_BIT     1
`define EM_SHIFT_BIT   0

// ----------------------------------------
// memory map and reset values
// ----------------------------------------
`define SPACE_CODE     8'h20
`define ONE_LINE_LAST  7'h4F
`define LINE1_LAST     7'h27
`define LINE2_FIRST    7'h40
`define LINE2_LAST     7'h67
`define GLYPH_LAST     7'h3F
`define TEXT_LAST      7'h7F
`define LINE1_LEN      7'h50
`define LINE2_LEN      7'h28
`define RST_BUS8       1'b1
`define RST_INC        1'b1
`define CURSOR_ROW     4'h7

// ----------------------------------------
// scan geometry and fifo size
// ----------------------------------------
`define SEG_W          40
`define COM_W          16
`define PIX_LAST       3'h4
`define CHAR_LAST      3'h7
`define ROWS_SMALL     4'h7
`define ROWS_TALL      4'hA
`define ROWS_TWO       4'hF
`define FIFO_DEPTH     4
`define FIFO_AW        2

`endif

// [char_lcd_host_interface.v]
// character display controller: host port, text and glyph memories, scan
`timescale 1ns/1ps
`include "lcd_defs.vh"

// What this block does
// - host bus runs 4-bit or 8-bit by width bit
// - two 8-bit holding registers: data and command
// - data read reloads holding from next location
// - data write lands in targeted memory location unless the fifo is full
// - command holding is write-only for host
// - select low, write low: command write
// - select low, read: busy on d7, counter below
// - select high, write low: data holding write
// - select high, read: return data holding
// - busy high during operation; commands refused
// - counter loaded by command, steps one per access
// - text memory holds 128 8-bit codes, eighty in use
// - one-line addresses contiguous from zero
// - two-line addresses from zero and hex 40
// - font rom: none, 240 rom codes get filler from code and row
// - eight custom glyphs shown by their codes
// - pixels shifted into 40-bit latch, then stored
// - 16-bit common register walks commons, segments out
// - duty 1/8, 1/11 single, 1/16 two-line
// - cursor and blink at counter position
// - upper nibble zero selects custom glyph
// - width bit high uses full 8-bit bus
// - 4-bit mode moves bytes as two transfers

// ----------------------------------------
// data fifo
// ----------------------------------------
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = `FIFO_AW
) (
    input  wire             ref_clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            push;
    wire            pop;

    assign out_valid = (wr_ptr != rd_ptr);
    assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
    assign out_data  = store[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge ref_clk)
    begin
        if (push)
            store[wr_ptr[AW-1:0]] <= in_data;
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// ----------------------------------------
// top
// ----------------------------------------
module char_lcd_host_interface (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        enable_pin,
    input  wire        register_select,
    input  wire        read_write,
    input  wire [7:0]  db_in,
    output reg  [7:0]  db_out,
    output reg         db_oe,
    output reg  [39:0] seg_out,
    output reg  [15:0] com_out
);
    // pin synchronisers
    reg [2:0]  e_sync;
    reg [1:0]  rs_sync;
    reg [1:0]  rw_sync;
    reg [7:0]  db_s1;
    reg [7:0]  db_s2;

    reg [7:0]  command_holding;
    reg [7:0]  data_holding;
    reg [6:0]  address_counter;
    reg        glyph_sel;
    reg        bus_width_select_bit;
    reg        two_line;
    reg        tall_font;
    reg        disp_on;
    reg        cur_on;
    reg        blink_on;
    reg        inc;
    reg        shift_en;
    reg [6:0]  offset;
    reg [`BUSY_W-1:0] busy_cnt;
    reg        clearing;
    reg [6:0]  clr_idx;
    reg        exec_go;
    reg        reload;
    reg        nib_phase;
    reg [3:0]  nib_hi;

    reg [7:0]  text_mem  [0:127];
    reg [7:0]  glyph_mem [0:63];

    reg [3:0]  row;
    reg [2:0]  chr;
    reg [2:0]  pix;
    reg [`SEG_W-1:0] seg_latch;
    reg [`BLINK_W-1:0] blink_cnt;

    wire e_rise = e_sync[1] && !e_sync[2];
    wire e_fall = !e_sync[1] && e_sync[2];
    wire rs_s   = rs_sync[1];
    wire rw_s   = rw_sync[1];
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire busy_flag = (busy_cnt != {`BUSY_W{1'b0}}) || clearing || exec_go
                     || reload || fifo_out_valid || !fifo_in_ready;
    wire last_nib  = bus_width_select_bit || nib_phase;
    wire [7:0] host_byte = bus_width_select_bit ? db_s2 : {nib_hi, db_s2[7:4]};
    wire data_wr   = e_fall && !rw_s && rs_s && last_nib;
    // a strobe edge owns the counter that cycle, so the fifo waits one clock
    wire drain_rdy = !exec_go && !reload && !clearing && !e_fall && (busy_cnt == {`BUSY_W{1'b0}});
    wire [31:0] exec_full = `EXEC_CYCLES;
    wire drain     = fifo_out_valid && drain_rdy;
    wire [7:0] rd_byte = glyph_sel ? glyph_mem[address_counter[5:0]] : text_mem[address_counter];
    wire [7:0] rd_sel  = rs_s ? data_holding : {busy_flag, address_counter};

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) data_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (data_wr),
        .in_ready  (fifo_in_ready),
        .in_data   (host_byte),
        .out_valid (fifo_out_valid),
        .out_ready (drain_rdy),
        .out_data  (fifo_out_data)
    );

    // next address with the per-mode wrap points
    function [6:0] step_addr;
        input [6:0] a;
        input       up;
        input       glyph;
        input       two;
        begin
            if (glyph)
                step_addr = up ? ((a + 7'h01) & `GLYPH_LAST) : ((a - 7'h01) & `GLYPH_LAST);
            else if (!two)
                step_addr = up ? ((a >= `ONE_LINE_LAST) ? 7'h00 : a + 7'h01)
                               : ((a == 7'h00) ? `ONE_LINE_LAST : a - 7'h01);
            else if (up)
                step_addr = (a == `LINE1_LAST) ? `LINE2_FIRST :
                            (a >= `LINE2_LAST) ? 7'h00 : a + 7'h01;
            else
                step_addr = (a == `LINE2_FIRST) ? `LINE1_LAST :
                            (a == 7'h00) ? `LINE2_LAST : a - 7'h01;
        end
    endfunction

    // display window offset, wraps at the line length
    function [6:0] step_offs;
        input [6:0] o;
        input       up;
        input       two;
        reg   [6:0] len;
        begin
            len = two ? `LINE2_LEN : `LINE1_LEN;
            if (up)
                step_offs = (o == len - 7'h01) ? 7'h00 : o + 7'h01;
            else
                step_offs = (o == 7'h00) ? len - 7'h01 : o - 7'h01;
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            e_sync  <= 3'h0;
            rs_sync <= 2'h0;
            rw_sync <= 2'h0;
            db_s1   <= 8'h00;
            db_s2   <= 8'h00;
        end
        else
        begin
            e_sync  <= {e_sync[1:0], enable_pin};
            rs_sync <= {rs_sync[0], register_select};
            rw_sync <= {rw_sync[0], read_write};
            db_s1   <= db_in;
            db_s2   <= db_s1;
        end
    end

    // ----------------------------------------
    // host port and command execution
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            command_holding      <= 8'h00;
            data_holding         <= 8'h00;
            address_counter      <= 7'h00;
            glyph_sel            <= 1'b0;
            bus_width_select_bit <= `RST_BUS8;
            two_line             <= 1'b0;
            tall_font            <= 1'b0;
            disp_on              <= 1'b0;
            cur_on               <= 1'b0;
            blink_on             <= 1'b0;
            inc                  <= `RST_INC;
            shift_en             <= 1'b0;
            offset               <= 7'h00;
            busy_cnt             <= {`BUSY_W{1'b0}};
            clearing             <= 1'b0;
            clr_idx              <= 7'h00;
            exec_go              <= 1'b0;
            reload               <= 1'b0;
            nib_phase            <= 1'b0;
            nib_hi               <= 4'h0;
            db_out               <= 8'h00;
            db_oe                <= 1'b0;
        end
        else
        begin
            exec_go <= 1'b0;
            reload  <= 1'b0;
            if (busy_cnt != {`BUSY_W{1'b0}})
                busy_cnt <= busy_cnt - 1'b1;
            if (clearing)
            begin
                clr_idx <= clr_idx + 7'h01;
                if (clr_idx == `TEXT_LAST)
                    clearing <= 1'b0;
            end
            if (reload)
                data_holding <= rd_byte;
            // read drive: byte or upper then lower nibble on lines 7..4
            if (e_rise && rw_s)
            begin
                db_oe <= 1'b1;
                if (bus_width_select_bit)
                    db_out <= rd_sel;
                else
                    db_out <= nib_phase ? {rd_sel[3:0], 4'h0} : {rd_sel[7:4], 4'h0};
            end
            if (e_fall)
            begin
                db_oe     <= 1'b0;
                nib_phase <= last_nib ? 1'b0 : 1'b1;
                if (!rw_s && !last_nib)
                    nib_hi <= db_s2[7:4];
                if (last_nib && !rw_s && rs_s)
                    data_holding <= host_byte;
                if (last_nib && !rw_s && !rs_s && !busy_flag)
                begin
                    command_holding <= host_byte;
                    exec_go         <= 1'b1;
                end
                if (last_nib && rw_s && rs_s)
                begin
                    address_counter <= step_addr(address_counter, inc, glyph_sel, two_line);
                    reload          <= 1'b1;
                end
            end
            else if (exec_go)
            begin
                busy_cnt <= exec_full[`BUSY_W-1:0];
                if (command_holding[`CMD_TEXT_ADDR])
                begin
                    address_counter <= command_holding[6:0];
                    glyph_sel       <= 1'b0;
                    reload          <= 1'b1;
                end
                else if (command_holding[`CMD_GLYPH_ADDR])
                begin
                    address_counter <= {1'b0, command_holding[5:0]};
                    glyph_sel       <= 1'b1;
                    reload          <= 1'b1;
                end
                else if (command_holding[`CMD_FUNCTION])
                begin
                    bus_width_select_bit <= command_holding[`FN_WIDTH_BIT];
                    two_line             <= command_holding[`FN_LINES_BIT];
                    tall_font            <= command_holding[`FN_FONT_BIT];
                    offset               <= 7'h00;
                end
                else if (command_holding[`CMD_SHIFT])
                begin
                    if (command_holding[`SH_DISP_BIT])
                        offset <= step_offs(offset, !command_holding[`SH_RIGHT_BIT], two_line);
                    else
                        address_counter <= step_addr(address_counter, command_holding[`SH_RIGHT_BIT],
                                                     glyph_sel, two_line);
                end
                else if (command_holding[`CMD_DISPLAY])
                begin
                    disp_on  <= command_holding[`DC_ON_BIT];
                    cur_on   <= command_holding[`DC_CURSOR_BIT];
                    blink_on <= command_holding[`DC_BLINK_BIT];
                end
                else if (command_holding[`CMD_ENTRY])
                begin
                    inc      <= command_holding[`EM_INC_BIT];
                    shift_en <= command_holding[`EM_SHIFT_BIT];
                end
                else if (command_holding[`CMD_HOME] || command_holding[`CMD_CLEAR])
                begin
                    address_counter <= 7'h00;
                    glyph_sel       <= 1'b0;
                    offset          <= 7'h00;
                    if (command_holding[`CMD_CLEAR])
                    begin
                        clearing <= 1'b1;
                        clr_idx  <= 7'h00;
                        inc      <= 1'b1;
                    end
                end
            end
            else if (drain)
            begin
                address_counter <= step_addr(address_counter, inc, glyph_sel, two_line);
                if (shift_en && !glyph_sel)
                    offset <= step_offs(offset, inc, two_line);
            end
        end
    end

    // ----------------------------------------
    // memories
    // ----------------------------------------
    // only 80 of the 128 text slots are reachable through the counter wrap
    always @(posedge ref_clk)
    begin
        if (clearing)
            text_mem[clr_idx] <= `SPACE_CODE;
        else if (drain && !glyph_sel)
            text_mem[address_counter] <= fifo_out_data;
        if (drain && glyph_sel)
            glyph_mem[address_counter[5:0]] <= fifo_out_data;
    end

    // ----------------------------------------
    // scan
    // ----------------------------------------
    wire [3:0] last_row  = two_line ? `ROWS_TWO : (tall_font ? `ROWS_TALL : `ROWS_SMALL);
    wire       line2     = two_line && row[3];
    wire [3:0] glyph_row = line2 ? {1'b0, row[2:0]} : row;
    wire [6:0] pos_raw   = {4'h0, chr} + offset;
    wire [6:0] line_len  = two_line ? `LINE2_LEN : `LINE1_LEN;
    wire [6:0] pos       = (pos_raw >= line_len) ? pos_raw - line_len : pos_raw;
    wire [6:0] scan_addr = line2 ? pos + `LINE2_FIRST : pos;
    wire [7:0] code      = text_mem[scan_addr];
    wire [7:0] glyph_px  = glyph_mem[{code[2:0], glyph_row[2:0]}];
    // no glyph table in this model: rom codes get a filler derived from the code
    wire [4:0] rom_px    = code[4:0] ^ {1'b0, glyph_row};
    wire [4:0] row_px    = (code[7:4] == 4'h0) ?
                           (glyph_row[3] ? 5'h00 : glyph_px[4:0]) : rom_px;
    wire       at_cursor = !glyph_sel && (scan_addr == address_counter);
    wire [4:0] shown_px  = (at_cursor && blink_on && blink_cnt[`BLINK_W-1]) ? 5'h1F :
                           (at_cursor && cur_on && glyph_row == `CURSOR_ROW) ? 5'h1F : row_px;
    wire       pixel     = disp_on && shown_px[pix];

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            row       <= 4'h0;
            chr       <= 3'h0;
            pix       <= `PIX_LAST;
            seg_latch <= {`SEG_W{1'b0}};
            seg_out   <= {`SEG_W{1'b0}};
            com_out   <= {`COM_W{1'b0}};
            blink_cnt <= {`BLINK_W{1'b0}};
        end
        else
        begin
            blink_cnt <= blink_cnt + 1'b1;
            seg_latch <= {seg_latch[`SEG_W-2:0], pixel};
            if (pix != 3'h0)
                pix <= pix - 3'h1;
            else
            begin
                pix <= `PIX_LAST;
                chr <= chr + 3'h1;
                if (chr == `CHAR_LAST)
                begin
                    seg_out <= {seg_latch[`SEG_W-2:0], pixel};
                    com_out <= {{(`COM_W-1){1'b0}}, 1'b1} << row;
                    row     <= (row >= last_row) ? 4'h0 : row + 4'h1;
                end
            end
        end
    end
endmodule

// [char_lcd_host_interface_assertions.sv]
// concurrent checks on the character display host port
`timescale 1ns/1ps

module char_lcd_checks (
    input wire        ref_clk,
    input wire        rst_n,
    input wire        enable_pin,
    input wire        read_write,
    input wire [7:0]  db_out,
    input wire        db_oe,
    input wire [39:0] seg_out,
    input wire [15:0] com_out
);
    // ----------------------------------------
    // row period helper
    // ----------------------------------------
    logic [15:0] com_prev;
    logic [7:0]  row_cnt;

    // saturates so a stalled scan still fails the period check
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            com_prev <= 16'h0000;
            row_cnt  <= 8'h00;
        end
        else
        begin
            com_prev <= com_out;
            if (com_out != com_prev)
                row_cnt <= 8'h00;
            else if (row_cnt != 8'hFF)
                row_cnt <= row_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    read_drive_a: assert property (
        $rose(db_oe) |-> read_write && enable_pin && $past(enable_pin, 2)) else $error("drive without read strobe");
    read_answer_a: assert property (
        $rose(enable_pin) && read_write |-> ##[2:6] db_oe) else $error("read strobe not answered");
    write_quiet_a: assert property (
        !read_write [*8] |-> !db_oe) else $error("bus driven during writes");
    release_a: assert property (
        !enable_pin [*6] |-> !db_oe) else $error("bus held after strobe");
    read_hold_a: assert property (
        db_oe && $past(db_oe) |-> $stable(db_out)) else $error("read data moved");
    com_onehot_a: assert property (
        $onehot0(com_out)) else $error("commons not one-hot");
    com_step_a: assert property (
        $changed(com_out) && $past(com_out) != 16'h0000 |->
        com_out == {$past(com_out[14:0]), 1'b0} || com_out == 16'h0001) else $error("common order broken");
    row_time_a: assert property (
        $changed(com_out) && $past(com_out) != 16'h0000 |-> row_cnt == 8'h27) else $error("row not 40 clocks");
    seg_latch_a: assert property (
        $changed(seg_out) |-> $changed(com_out)) else $error("segments moved mid-row");
    idle_blank_a: assert property (
        com_out == 16'h0000 |-> seg_out == 40'h0) else $error("segments before first row");
endmodule

bind char_lcd_host_interface char_lcd_checks chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .enable_pin(enable_pin),
    .read_write(read_write), .db_out(db_out), .db_oe(db_oe), .seg_out(seg_out), .com_out(com_out));

// [host_bus_model.sv]
// host processor model driving the display's parallel bus
`timescale 1ns/1ps

module host_bus_model (
    input  wire        ref_clk,
    output logic       enable_pin,
    output logic       register_select,
    output logic       read_write,
    output logic [7:0] db_in,
    input  wire  [7:0] db_out,
    input  wire        db_oe
);
    logic narrow;

    initial
    begin
        enable_pin      = 1'b0;
        register_select = 1'b0;
        read_write      = 1'b1;
        db_in           = 8'h00;
        narrow          = 1'b0;
    end

    // ----------------------------------------
    // one strobe, held well past the synchroniser
    // ----------------------------------------
    task strobe(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        register_select <= rs;
        read_write      <= rw;
        db_in           <= d;
        enable_pin      <= 1'b1;
        repeat (8) @(posedge ref_clk);
        // undriven lines float to the pull-up level
        q = db_oe ? db_out : 8'hFF;
        enable_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        // released bus shows the inverse, never a stale copy
        db_in <= ~d;
        // long gap also covers the half-period wait after busy drops
        repeat (4) @(posedge ref_clk);
    endtask

    task xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] hi;
        logic [7:0] lo;
        if (narrow)
        begin
            strobe(rs, rw, {d[7:4], ~d[7:4]}, hi);
            strobe(rs, rw, {d[3:0], ~d[3:0]}, lo);
            q = {hi[7:4], lo[7:4]};
        end
        else
            strobe(rs, rw, d, q);
    endtask
endmodule

// [tb_top.sv]
// self-checking bench for the character display host port
`timescale 1ns/1ps

module tb_top;
    logic        ref_clk;
    logic        rst_n;
    wire         enable_pin;
    wire         register_select;
    wire         read_write;
    wire  [7:0]  db_in;
    wire  [7:0]  db_out;
    wire         db_oe;
    wire  [39:0] seg_out;
    wire  [15:0] com_out;
    int          err_count;
    int          cmp_count;
    logic [7:0]  s;
    logic [7:0]  q;

    char_lcd_host_interface dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .enable_pin(enable_pin),
        .register_select(register_select), .read_write(read_write), .db_in(db_in), .db_out(db_out),
        .db_oe(db_oe), .seg_out(seg_out), .com_out(com_out));
    host_bus_model host_u (.ref_clk(ref_clk), .enable_pin(enable_pin), .register_select(register_select),
        .read_write(read_write), .db_in(db_in), .db_out(db_out), .db_oe(db_oe));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task check(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // last status stays in s
    task wait_idle();
        int n;
        n = 0;
        s = 8'hFF;
        while (s[7] !== 1'b0 && n < 400)
        begin
            host_u.xfer(1'b0, 1'b1, 8'h5A, s);
            n++;
        end
        if (s[7] !== 1'b0)
            check(s, 8'h00, "busy stuck");
    endtask

    task cmd(input logic [7:0] c);
        wait_idle();
        host_u.xfer(1'b0, 1'b0, c, q);
    endtask

    task rd(input logic [7:0] exp, input string what);
        host_u.xfer(1'b1, 1'b1, 8'hA5, q);
        check(q, exp, what);
    endtask

    task test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // clock, reset, watchdog
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (80000) @(posedge ref_clk);
        err_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        test_done();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        err_count = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        host_u.xfer(1'b0, 1'b1, 8'h5A, s);
        check(s, 8'h00, "status after reset");
        host_u.xfer(1'b0, 1'b0, 8'h01, q);
        host_u.xfer(1'b0, 1'b1, 8'h5A, s);
        check({s[7], 7'h00}, 8'h80, "busy after clear");
        $display("test reset and clear done");
        cmd(8'hCF);
        host_u.xfer(1'b1, 1'b0, 8'hA5, q);
        wait_idle();
        check(s, 8'h00, "one-line wrap");
        cmd(8'hCF);
        wait_idle();
        rd(8'hA5, "read back");
        wait_idle();
        check(s, 8'h00, "step after read");
        $display("test one-line done");
        cmd(8'h90);
        host_u.xfer(1'b0, 1'b0, 8'hA0, q);
        wait_idle();
        check(s, 8'h10, "busy command dropped");
        $display("test refusal done");
        cmd(8'h38);
        cmd(8'h0F);
        cmd(8'hA7);
        host_u.xfer(1'b1, 1'b0, 8'h3C, q);
        wait_idle();
        check(s, 8'h40, "two-line jump");
        cmd(8'h10);
        wait_idle();
        check(s, 8'h27, "cursor left across lines");
        cmd(8'h04);
        host_u.xfer(1'b1, 1'b0, 8'h77, q);
        wait_idle();
        check(s, 8'h26, "decrement after write");
        cmd(8'h06);
        cmd(8'h02);
        wait_idle();
        check(s, 8'h00, "return home");
        $display("test two-line done");
        cmd(8'h80);
        for (int i = 1; i <= 5; i++)
            host_u.xfer(1'b1, 1'b0, 8'(i * 17), q);
        wait_idle();
        check(s, 8'h04, "fifo kept four");
        cmd(8'h80);
        wait_idle();
        for (int i = 1; i <= 4; i++)
            rd(8'(i * 17), "fifo data");
        rd(8'h20, "fifth byte lost");
        $display("test fifo done");
        cmd(8'h48);
        host_u.xfer(1'b1, 1'b0, 8'h1F, q);
        host_u.xfer(1'b1, 1'b0, 8'h0E, q);
        wait_idle();
        check(s, 8'h0A, "glyph address");
        cmd(8'h48);
        wait_idle();
        rd(8'h1F, "glyph row 0");
        rd(8'h0E, "glyph row 1");
        $display("test glyph done");
        cmd(8'h28);
        host_u.narrow = 1'b1;
        cmd(8'h85);
        host_u.xfer(1'b1, 1'b0, 8'h9C, q);
        wait_idle();
        check(s, 8'h06, "nibble status");
        cmd(8'h85);
        wait_idle();
        rd(8'h9C, "nibble data");
        $display("test four-bit done");
        test_done();
    end
endmodule
